// >>> src_cal_pkg.sv
package src_cal_pkg;
	// Register offsets (serial register port byte addresses)
	localparam logic [14:0] REG_ENABLE = 15'h02B0;
	localparam logic [14:0] REG_CONFIG = 15'h02B1;
	localparam logic [14:0] REG_STATUS_0 = 15'h02B2;
	localparam logic [14:0] REG_STATUS_1 = 15'h02B3;
	localparam logic [14:0] REG_STATUS_2 = 15'h02B4;
	localparam logic [14:0] REG_DELAY_0 = 15'h02B5;
	localparam logic [14:0] REG_DELAY_1 = 15'h02B6;
	localparam logic [14:0] REG_DELAY_2 = 15'h02B7;
	// Reset values
	localparam logic [7:0] CONFIG_RST = 8'h05;
	localparam logic [23:0] DELAY_RST = 24'h000000;
	// Field positions
	localparam int AVG_LSB = 2;
	localparam int LEN_LSB = 0;
	localparam int DONE_BIT = 17;
	localparam int RESULT_W = 17;
	localparam int INV_BIT = 16;
	// Calibration timing: 256 * 19 * 4 * (avg + len + 2) cycles at most
	localparam int CAL_BASE = 256 * 19 * 4;
	localparam int CAL_OFFS = 2;
	localparam int SHIFT_STEP = 2;
	localparam int BASE_LOG = 2;
	// Longest supported reference period per length code, in clock cycles
	localparam int PERIOD_MAX_0 = 85;
	localparam int PERIOD_MAX_1 = 1100;
	localparam int PERIOD_MAX_2 = 5200;
	localparam int PERIOD_MAX_3 = 21580;
	typedef enum logic [1:0] {SC_IDLE, SC_RUN, SC_DONE} src_state_t;
endpackage : src_cal_pkg

// >>> src_cal_ctrl.sv
`timescale 1ns/1ps
module src_cal_ctrl
	import src_cal_pkg::*;
#(
	parameter int CNT_W = 24
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Register port
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [14:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// Reference timing measurement
	input wire logic i_sysref_edge,
	input wire logic [RESULT_W-1:0] i_meas_result,
	// Delay control and status
	output logic [RESULT_W-1:0] o_delay_setting,
	output logic o_cal_busy,
	output logic o_period_fault
);

	////////////////////////////////////////////////////////////////////////////
	// Decode
	function automatic logic [CNT_W-1:0] cal_len(input logic [1:0] avg, input logic [1:0] len);
		logic [31:0] t;
		// One less than the bound: the edge into done is the last run cycle
		t = CAL_BASE * (32'(avg) + 32'(len) + CAL_OFFS) - 32'h1;
		cal_len = t[CNT_W-1:0];
	endfunction : cal_len

	function automatic logic [31:0] period_max(input logic [1:0] len);
		unique case (len)
			2'h0: period_max = PERIOD_MAX_0;
			2'h1: period_max = PERIOD_MAX_1;
			2'h2: period_max = PERIOD_MAX_2;
			2'h3: period_max = PERIOD_MAX_3;
		endcase
	endfunction : period_max

	// Four raised to one more than the code: 4, 16, 64 or 256
	function automatic logic [31:0] pow4_step(input logic [1:0] code);
		pow4_step = 32'h1 << (BASE_LOG + SHIFT_STEP * int'(code));
	endfunction : pow4_step

	////////////////////////////////////////////////////////////////////////////
	// State
	logic enable_ff, nxt_enable;
	logic [7:0] config_ff, nxt_config;
	logic [23:0] delay_ff, nxt_delay;
	logic [RESULT_W-1:0] result_ff, nxt_result;
	src_state_t state_ff, nxt_state;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [31:0] per_ff, nxt_per;
	logic [31:0] acyc_ff, nxt_acyc;
	logic [31:0] anum_ff, nxt_anum;
	logic [RESULT_W-1:0] meas_ff, nxt_meas;
	logic fault_ff, nxt_fault;
	logic [7:0] rdata_ff, nxt_rdata;
	logic [1:0] avg_sel, len_sel;
	logic [23:0] status;

	assign avg_sel = config_ff[AVG_LSB+1:AVG_LSB];
	assign len_sel = config_ff[LEN_LSB+1:LEN_LSB];
	// Status word: complete flag above result
	assign status = {6'h00, state_ff == SC_DONE && enable_ff, result_ff};

	always_comb begin
		nxt_enable = enable_ff;
		nxt_config = config_ff;
		nxt_delay = delay_ff;
		nxt_result = result_ff;
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_per = per_ff;
		nxt_acyc = acyc_ff;
		nxt_anum = anum_ff;
		nxt_meas = meas_ff;
		nxt_fault = fault_ff;
		nxt_rdata = rdata_ff;
		if (i_reg_wr) begin
			// Status has no write path
			unique case (i_reg_addr)
				REG_ENABLE: nxt_enable = i_reg_wdata[0];
				REG_CONFIG: nxt_config = {4'h0, i_reg_wdata[3:0]};
				REG_DELAY_0: nxt_delay[7:0] = i_reg_wdata;
				REG_DELAY_1: nxt_delay[15:8] = i_reg_wdata;
				REG_DELAY_2: nxt_delay[23:16] = {7'h00, i_reg_wdata[0]};
				default: ;
			endcase
		end
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				REG_ENABLE: nxt_rdata = {7'h00, enable_ff};
				REG_CONFIG: nxt_rdata = config_ff;
				REG_STATUS_0: nxt_rdata = status[7:0];
				REG_STATUS_1: nxt_rdata = status[15:8];
				REG_STATUS_2: nxt_rdata = status[23:16];
				REG_DELAY_0: nxt_rdata = delay_ff[7:0];
				REG_DELAY_1: nxt_rdata = delay_ff[15:8];
				REG_DELAY_2: nxt_rdata = delay_ff[23:16];
				default: nxt_rdata = 8'h00;
			endcase
		end
		// Accumulation sequencer: one measurement is a run of accumulations
		if (state_ff == SC_RUN) begin
			if (acyc_ff > 32'h1) begin
				nxt_acyc = acyc_ff - 32'h1;
			end else begin
				nxt_acyc = pow4_step(len_sel);
				if (anum_ff > 32'h1) begin
					nxt_anum = anum_ff - 32'h1;
				end else begin
					// Measurement complete: keep its result for the end of the run
					nxt_anum = pow4_step(avg_sel);
					nxt_meas = i_meas_result;
				end
			end
		end
		// Reference period watch against the selected length code
		if (state_ff == SC_RUN) begin
			if (i_sysref_edge) begin
				nxt_per = 32'h0;
			end else if (per_ff != 32'hFFFFFFFF) begin
				nxt_per = per_ff + 32'h1;
			end
			if (per_ff > period_max(len_sel)) begin
				nxt_fault = 1'b1;
			end
		end
		unique case (state_ff)
			SC_IDLE: begin
				if (nxt_enable && !enable_ff) begin
					nxt_state = SC_RUN;
					// Accumulation count x length steps stays within the time bound
					nxt_cnt = cal_len(avg_sel, len_sel);
					nxt_acyc = pow4_step(len_sel);
					nxt_anum = pow4_step(avg_sel);
					nxt_per = 32'h0;
					nxt_fault = 1'b0;
				end
			end
			SC_RUN: begin
				if (!nxt_enable) begin
					nxt_state = SC_IDLE;
				end else if (cnt_ff == '0) begin
					nxt_state = SC_DONE;
					nxt_result = nxt_meas;
				end else begin
					nxt_cnt = cnt_ff - CNT_W'(1);
				end
			end
			SC_DONE: begin
				if (!nxt_enable) begin
					nxt_state = SC_IDLE;
				end
			end
			default: nxt_state = SC_IDLE;
		endcase
		// Fresh rising edge restarts and drops the flag
		if (state_ff != SC_IDLE && nxt_enable && !enable_ff) begin
			nxt_state = SC_RUN;
			nxt_cnt = cal_len(avg_sel, len_sel);
			nxt_acyc = pow4_step(len_sel);
			nxt_anum = pow4_step(avg_sel);
			nxt_per = 32'h0;
			nxt_fault = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			enable_ff <= 1'b0;
			config_ff <= CONFIG_RST;
			delay_ff <= DELAY_RST;
			result_ff <= '0;
			state_ff <= SC_IDLE;
			cnt_ff <= '0;
			per_ff <= 32'h0;
			acyc_ff <= '0;
			anum_ff <= '0;
			meas_ff <= '0;
			fault_ff <= 1'b0;
			rdata_ff <= 8'h00;
		end else begin
			enable_ff <= nxt_enable;
			config_ff <= nxt_config;
			delay_ff <= nxt_delay;
			result_ff <= nxt_result;
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			per_ff <= nxt_per;
			acyc_ff <= nxt_acyc;
			anum_ff <= nxt_anum;
			meas_ff <= nxt_meas;
			fault_ff <= nxt_fault;
			rdata_ff <= nxt_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign o_reg_rdata = rdata_ff;
	// Manual delay ignored while enabled
	assign o_delay_setting = enable_ff ? result_ff : delay_ff[RESULT_W-1:0];
	assign o_cal_busy = state_ff == SC_RUN;
	assign o_period_fault = fault_ff;

endmodule : src_cal_ctrl

// >>> src_cal_chk.sv
`timescale 1ns/1ps
module src_cal_chk
	import src_cal_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [14:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic [RESULT_W-1:0] o_delay_setting,
	input wire logic o_cal_busy,
	input wire logic o_period_fault
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	cfg_rsvd_a: assert property (i_reg_rd && i_reg_addr == REG_CONFIG |=> o_reg_rdata[7:4] == 4'h0)
		else $error("config high bits set");
	stat_rsvd_a: assert property (i_reg_rd && i_reg_addr == REG_STATUS_2 |=> o_reg_rdata[7:2] == 6'h00)
		else $error("status high bits set");
	done_busy_a: assert property (i_reg_rd && i_reg_addr == REG_STATUS_2 && o_cal_busy |=> !o_reg_rdata[1])
		else $error("done while running");
	rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("read data moved");
	stop_run_a: assert property (i_reg_wr && i_reg_addr == REG_ENABLE && !i_reg_wdata[0] |=> !o_cal_busy)
		else $error("run kept after disable");
	done_clr_a: assert property (i_reg_wr && i_reg_addr == REG_ENABLE && !i_reg_wdata[0] ##1 i_reg_rd && i_reg_addr == REG_STATUS_2 |=> !o_reg_rdata[1])
		else $error("done kept after disable");
	fault_clr_a: assert property ($rose(o_cal_busy) |-> !o_period_fault)
		else $error("fault at start");
	delay_hold_a: assert property (o_cal_busy && $past(o_cal_busy) |-> $stable(o_delay_setting))
		else $error("delay moved in run");
	cover property ($rose(o_cal_busy));
	cover property ($rose(o_period_fault));
	cover property ($fell(o_cal_busy));
	cover property (i_reg_rd && i_reg_addr == REG_STATUS_2 ##1 o_reg_rdata[1]);
endmodule : src_cal_chk
bind src_cal_ctrl src_cal_chk u_chk (.i_core_clk, .i_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr,
	.i_reg_wdata, .o_reg_rdata, .o_delay_setting, .o_cal_busy, .o_period_fault);

// >>> sysref_calibration_control_tb.sv
`timescale 1ns/1ps
module sysref_calibration_control_tb;
	import src_cal_pkg::*;
	logic i_core_clk = 0, i_rst = 1, i_reg_wr = 0, i_reg_rd = 0, i_sysref_edge = 0;
	logic [14:0] i_reg_addr = '0;
	logic [7:0] i_reg_wdata = '0, o_reg_rdata, q;
	logic [RESULT_W-1:0] i_meas_result = '0, o_delay_setting;
	logic o_cal_busy, o_period_fault;
	logic [23:0] m, e;
	int bad_count = 0, checks = 0, k = 0, p = 0, sp = 50;
	int unsigned rs = 94085;
	logic mdl_en = 1'b0, mdl_fin = 1'b0;
	logic [7:0] mdl_cfg = CONFIG_RST;
	logic [23:0] mdl_dly = DELAY_RST;
	logic [RESULT_W-1:0] mdl_res = '0;
	logic [7:0] exp_q[$];
	src_cal_ctrl dut (.i_core_clk, .i_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
		.o_reg_rdata, .i_sysref_edge, .i_meas_result, .o_delay_setting, .o_cal_busy, .o_period_fault);
	function automatic int unsigned xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xs
	task automatic chk(input logic [23:0] g, input logic [23:0] x);
		checks++;
		if (g !== x) begin
			bad_count++;
			$display("unexpected %0t got %h want %h", $time, g, x);
		end
	endtask : chk
	function automatic logic [7:0] mdl_rd(input logic [14:0] a);
		logic [23:0] s;
		s = {6'h00, mdl_en && mdl_fin, mdl_res};
		case (a)
			REG_ENABLE: mdl_rd = {7'h00, mdl_en};
			REG_CONFIG: mdl_rd = mdl_cfg;
			REG_STATUS_0: mdl_rd = s[7:0];
			REG_STATUS_1: mdl_rd = s[15:8];
			REG_STATUS_2: mdl_rd = s[23:16];
			REG_DELAY_0: mdl_rd = mdl_dly[7:0];
			REG_DELAY_1: mdl_rd = mdl_dly[15:8];
			REG_DELAY_2: mdl_rd = mdl_dly[23:16];
			default: mdl_rd = 8'h00;
		endcase
	endfunction : mdl_rd
	function automatic void mdl_wr(input logic [14:0] a, input logic [7:0] d);
		case (a)
			REG_ENABLE: begin
				if (d[0] && !mdl_en) mdl_fin = 1'b0;
				mdl_en = d[0];
			end
			REG_CONFIG: mdl_cfg = {4'h0, d[3:0]};
			REG_DELAY_0: mdl_dly[7:0] = d;
			REG_DELAY_1: mdl_dly[15:8] = d;
			REG_DELAY_2: mdl_dly[23:16] = {7'h00, d[0]};
			default: ;
		endcase
	endfunction : mdl_wr
	task automatic rw(input logic [14:0] a, input logic [7:0] d, input logic w);
		@(posedge i_core_clk);
		#1 i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = w;
		i_reg_rd = !w;
		if (w) mdl_wr(a, d);
		else exp_q.push_back(mdl_rd(a));
		@(posedge i_core_clk);
		#1 i_reg_wr = 0;
		i_reg_rd = 0;
		q = o_reg_rdata;
		if (!w) chk(q, exp_q.pop_front());
	endtask : rw
	task automatic summarize();
		if (bad_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize
	initial forever #10 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) begin
		p <= p + 1;
		i_sysref_edge <= #1 (p % sp == 0);
	end
	initial begin
		#1500000;
		bad_count++;
		summarize();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge i_core_clk);
		#1 i_rst = 0;
		rw(REG_CONFIG, 8'h00, 0);
		chk(q, CONFIG_RST);
		m = 24'(xs());
		rw(REG_CONFIG, m[7:0], 1);
		rw(REG_CONFIG, 8'h00, 0);
		chk(q, m[3:0]);
		rw(REG_STATUS_2, 8'hFF, 1);
		rw(REG_STATUS_2, 8'h00, 0);
		chk(q, 8'h00);
		rw(REG_CONFIG, 8'h00, 1);
		m = 24'(xs());
		i_meas_result = 17'(xs());
		for (int i = 0; i < 3; i++) rw(15'(REG_DELAY_0 + i), m[8*i+:8], 1);
		chk(o_delay_setting, m[16:0]);
		rw(REG_ENABLE, 8'h01, 1);
		while (o_cal_busy === 1'b1 && k < 50000) begin
			@(posedge i_core_clk);
			#1 k++;
		end
		mdl_fin = 1'b1;
		mdl_res = i_meas_result;
		chk(k[23:0], 24'(CAL_BASE * CAL_OFFS));
		chk(o_period_fault, 24'h0);
		chk(o_delay_setting, i_meas_result);
		e = {7'h01, i_meas_result};
		for (int i = 0; i < 3; i++) begin
			rw(15'(REG_STATUS_0 + i), 8'h00, 0);
			chk(q, e[8*i+:8]);
		end
		for (int i = 0; i < 3; i++) rw(15'(REG_DELAY_0 + i), e[8*i+:8], 1);
		rw(REG_ENABLE, 8'h00, 1);
		chk(o_delay_setting, i_meas_result);
		rw(REG_STATUS_2, 8'h00, 0);
		chk(q[1], 1'b0);
		sp = 100000;
		rw(REG_ENABLE, 8'h01, 1);
		repeat (100) @(posedge i_core_clk);
		#1 chk(o_period_fault, 24'h1);
		rw(REG_ENABLE, 8'h00, 1);
		rw(REG_ENABLE, 8'h01, 1);
		chk({o_cal_busy, o_period_fault}, 24'h2);
		rw(REG_STATUS_2, 8'h00, 0);
		chk(q[1], 1'b0);
		rw(REG_ENABLE, 8'h00, 1);
		summarize();
	end
endmodule : sysref_calibration_control_tb
